// ===== rtl/tmr8_pkg.sv
/*
  Constants, field layout and carrier types for the 8-bit timer with shared prescaler.
  Assumes a 32-bit classic Wishbone register bus and one instruction-cycle clock.
*/
// Function
// - Clock select clear and no prescaler: count advances each instruction cycle.
// - Counting is suppressed for two cycles after every count register write.
// - Clock select set and no prescaler: count advances on each active external input edge.
// - Prescaler serves timer or watchdog only; assign bit clear selects timer.
// - Prescaler on timer: 3-bit rate field gives eight ratios, 1:2 to 1:256.
// - Undivided 1:1 counting exists only while the prescaler serves the watchdog.
// - Prescaler count is never readable or writable by software.
// - With prescaler on timer, each count write also zeroes the prescaler.
// - With prescaler on watchdog, watchdog clear zeroes the prescaler too.
// - Wrap from FFh to 00h sets overflow flag regardless of interrupt enable.
// - Overflow flag stays set until software clears it; hardware never clears.
// - Interrupt request only when overflow flag and its enable are both set.
// - Count is frozen during sleep, so no overflow or wake happens then.
// - Edge select one counts falling external edges; zero counts rising edges.
// - In counter mode the prescaler output is resampled onto the internal clock.
package tmr8_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the bus
  localparam int unsigned ADR_W       = 4;
  localparam logic [3:0]  OFF_COUNT   = 4'h0;
  localparam logic [3:0]  OFF_CONFIG  = 4'h4;
  localparam logic [3:0]  OFF_STATUS  = 4'h8;
  localparam logic [3:0]  OFF_INTEN   = 4'hc;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned CFG_SRC_BIT  = 5;
  localparam int unsigned CFG_EDGE_BIT = 4;
  localparam int unsigned CFG_PSA_BIT  = 3;
  localparam int unsigned CFG_RATE_LSB = 0;
  localparam int unsigned RATE_W       = 3;
  localparam int unsigned STAT_OVF_BIT = 0;
  localparam int unsigned EN_OVF_BIT   = 0;
  localparam int unsigned EN_GLOB_BIT  = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counts
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] COUNT_MAX  = 8'hff;
  localparam logic [5:0] CONFIG_RST = 6'h3f;
  localparam logic [1:0] WR_HOLD    = 2'h2;
  localparam logic [3:0] SHIFT_ONE  = 4'h1;

  // Timer configuration as software sees it
  typedef struct packed {
    logic              clk_src;
    logic              edge_fall;
    logic              psa_wdt;
    logic [RATE_W-1:0] rate;
  } tmr8_cfg_t;

  // One bus request, grouped as a unit straight from the bus inputs, not registered
  typedef struct packed {
    logic [ADR_W-1:0] adr;
    logic             we;
    logic             lane0;
    logic [7:0]       dat;
  } tmr8_req_t;

  // Mask of the low n bits of the prescaler count
  function automatic logic [7:0] low_mask(input logic [3:0] n);
    logic [8:0] t;
    t = (9'h001 << n) - 9'h001;
    return t[7:0];
  endfunction

endpackage

// ===== rtl/tmr8_presc.sv
/*
  Shared 8-bit prescaler: counts input ticks and passes one in 2^shift.
  Assumes tick_i is a one-cycle pulse on clk_i; clear_i wins over counting.
*/
`timescale 1ns/1ns
module tmr8_presc #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Control
  input  wire logic             clear_i,
  input  wire logic             tick_i,
  input  wire logic [3:0]       shift_i,
  // Result
  output logic                  tick_o,
  output logic [WIDTH-1:0]      count_o
);

  logic [WIDTH-1:0] mask;

  assign mask   = WIDTH'(tmr8_pkg::low_mask(shift_i));
  // Pass a tick when every low bit under the tap is already one
  assign tick_o = tick_i && !clear_i && ((count_o & mask) == mask);

  // Count is internal state only; no bus path reaches it
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      count_o <= '0;
    end else if (tick_i) begin
      count_o <= count_o + WIDTH'(1);
    end
  end

endmodule // tmr8_presc

// ===== rtl/tmr8_sync.sv
/*
  Three-stage synchroniser with edge pulses for the external count input.
  Assumes the pin is asynchronous to clk_i; the level counts once stages two and three agree.
*/
`timescale 1ns/1ns
module tmr8_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pin side
  input  wire logic pin_i,
  // Edge pulses
  output logic      rise_o,
  output logic      fall_o
);

  logic [2:0] stage_r;
  logic       level_r;

  // First stage is read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage_r <= 3'h0;
    end else begin
      stage_r <= {stage_r[1:0], pin_i};
    end
  end

  // Accept a new level only when two settled stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_r <= 1'b0;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end else begin
      rise_o <= (stage_r[1] == stage_r[2]) && stage_r[2] && !level_r;
      fall_o <= (stage_r[1] == stage_r[2]) && !stage_r[2] && level_r;
      if (stage_r[1] == stage_r[2]) begin
        level_r <= stage_r[2];
      end
    end
  end

endmodule // tmr8_sync

// ===== rtl/tmr8_top.sv
/*
  Timer block top: Wishbone slave, 8-bit count, shared prescaler, overflow interrupt.
  Assumes one 10 MHz instruction-cycle clock, synchronous active-high reset, and a
  watchdog outside that supplies its base tick and its clear instruction as pulses.
*/
`timescale 1ns/1ns
module tmr8_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // External count pin
  input  wire logic        external_count_input_i,
  // Core and watchdog side
  input  wire logic        sleep_i,
  input  wire logic        watchdog_clear_i,
  input  wire logic        wdt_tick_i,
  output logic             wdt_tick_o,
  // Interrupt
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  tmr8_pkg::tmr8_cfg_t cfg_r;
  tmr8_pkg::tmr8_req_t req;
  logic [7:0]          timer_count_r;
  logic [1:0]          hold_r;
  logic                inc_r;
  logic                overflow_flag_r;
  logic                overflow_int_enable_r;
  logic                global_enable_r;
  logic                bus_req;
  logic                bus_wr;
  logic                wr_count;
  logic                wr_config;
  logic                wr_status;
  logic                wr_inten;
  logic [7:0]          rd_byte;
  logic                ext_rise;
  logic                ext_fall;
  logic                ext_edge;
  logic                src_tick;
  logic                presc_in;
  logic                presc_out;
  logic                presc_clear;
  logic [3:0]          presc_shift;
  logic [7:0]          presc_count;
  logic                inc_ok;
  logic                ovf_evt;
  logic                flag_clear;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: ack one cycle after the request, writes act on the ack edge
  // The !ack term refuses a strobe still high in the ack cycle, so one access never counts twice
  assign req       = '{adr: wb_adr_i, we: wb_we_i, lane0: wb_sel_i[0], dat: wb_dat_i[7:0]};
  assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr    = wb_cyc_i && wb_stb_i && wb_ack_o && req.we && req.lane0;
  assign wr_count  = bus_wr && (req.adr == tmr8_pkg::OFF_COUNT);
  assign wr_config = bus_wr && (req.adr == tmr8_pkg::OFF_CONFIG);
  assign wr_status = bus_wr && (req.adr == tmr8_pkg::OFF_STATUS);
  assign wr_inten  = bus_wr && (req.adr == tmr8_pkg::OFF_INTEN);

  // Read mux; unmapped addresses read zero and the prescaler has no address
  always_comb begin
    rd_byte = 8'h00;
    case (req.adr)
      tmr8_pkg::OFF_COUNT:  rd_byte = timer_count_r;
      tmr8_pkg::OFF_CONFIG: rd_byte = 8'(cfg_r);
      tmr8_pkg::OFF_STATUS: rd_byte[tmr8_pkg::STAT_OVF_BIT] = overflow_flag_r;
      tmr8_pkg::OFF_INTEN: begin
        rd_byte[tmr8_pkg::EN_OVF_BIT]  = overflow_int_enable_r;
        rd_byte[tmr8_pkg::EN_GLOB_BIT] = global_enable_r;
      end
      default:              rd_byte = 8'h00;
    endcase
  end

  // Ack and read data; both come from flip-flops
  // Read data is loaded on the taking edge, so it shows the state one cycle before the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= 32'(rd_byte);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration; software keeps the switching order when moving the prescaler
  // A write with sel[0] low is acknowledged but leaves every bit as it was
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= tmr8_pkg::tmr8_cfg_t'(tmr8_pkg::CONFIG_RST);
    end else if (wr_config) begin
      cfg_r <= tmr8_pkg::tmr8_cfg_t'(req.dat[tmr8_pkg::CFG_SRC_BIT:tmr8_pkg::CFG_RATE_LSB]);
    end
  end

  // Interrupt enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_int_enable_r <= 1'b0;
      global_enable_r       <= 1'b0;
    end else if (wr_inten) begin
      overflow_int_enable_r <= req.dat[tmr8_pkg::EN_OVF_BIT];
      global_enable_r       <= req.dat[tmr8_pkg::EN_GLOB_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock source: external edge passes five flops (three sync stages, edge pulse, resample) before it counts
  // Limitation: a pin level shorter than two clocks may be missed entirely
  tmr8_sync u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (external_count_input_i),
    .rise_o (ext_rise),
    .fall_o (ext_fall)
  );

  assign ext_edge = cfg_r.edge_fall ? ext_fall : ext_rise;
  // Timer mode ticks every instruction cycle, counter mode on the chosen edge
  assign src_tick = cfg_r.clk_src ? ext_edge : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Shared prescaler: one owner at a time
  // Timer side freezes in sleep; the watchdog side keeps running so it can still wake the core
  assign presc_in    = cfg_r.psa_wdt ? wdt_tick_i : (src_tick && !sleep_i);
  // Timer ratios start at 1:2, so no timer setting divides by one
  assign presc_shift = cfg_r.psa_wdt ? {1'b0, cfg_r.rate}
                                     : {1'b0, cfg_r.rate} + tmr8_pkg::SHIFT_ONE;
  // A count write clears it only for the timer, the watchdog clear only for the watchdog
  assign presc_clear = cfg_r.psa_wdt ? watchdog_clear_i : wr_count;

  tmr8_presc #(
    .WIDTH (8)
  ) u_presc (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (presc_clear),
    .tick_i  (presc_in),
    .shift_i (presc_shift),
    .tick_o  (presc_out),
    .count_o (presc_count)
  );

  // Resample the divided tick onto the internal clock before it reaches the count
  // Trade-off: one cycle of latency in every mode buys a count that moves on one edge only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inc_r      <= 1'b0;
      wdt_tick_o <= 1'b0;
    end else begin
      inc_r      <= cfg_r.psa_wdt ? src_tick : presc_out;
      wdt_tick_o <= cfg_r.psa_wdt && presc_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count register
  // Ticks lost to sleep, to the write cycle or to the hold window are dropped, never queued
  assign inc_ok  = inc_r && (hold_r == 2'h0) && !sleep_i && !wr_count;
  assign ovf_evt = inc_ok && (timer_count_r == tmr8_pkg::COUNT_MAX);

  // Write hold: two cycles without increments follow each count write
  // Software that wants an exact time writes a value two counts ahead
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_r <= 2'h0;
    end else if (wr_count) begin
      hold_r <= tmr8_pkg::WR_HOLD;
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end
  end

  // A write wins over an increment in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_count_r <= tmr8_pkg::COUNT_RST;
    end else if (wr_count) begin
      timer_count_r <= req.dat;
    end else if (inc_ok) begin
      timer_count_r <= timer_count_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow flag: write one to clear; a wrap in the same cycle keeps it set
  // Set wins so that a wrap racing a software clear is never lost
  assign flag_clear = wr_status && req.dat[tmr8_pkg::STAT_OVF_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_flag_r <= 1'b0;
    end else if (ovf_evt) begin
      overflow_flag_r <= 1'b1;
    end else if (flag_clear) begin
      overflow_flag_r <= 1'b0;
    end
  end

  // Level interrupt, qualified by both enables
  // Registered so irq_o comes from a flop; it trails the flag by one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= overflow_flag_r && overflow_int_enable_r && global_enable_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  hold_two_cycles_a: assert property (wr_count |=> !inc_ok ##1 !inc_ok)
    else $error("count advanced within two cycles of a write");

  timer_every_cycle_a: assert property (
    (cfg_r.psa_wdt && !cfg_r.clk_src) |=> inc_r)
    else $error("undivided timer missed a cycle");

  ext_edge_count_a: assert property (
    (cfg_r.psa_wdt && cfg_r.clk_src) |=> (inc_r == $past(ext_edge)))
    else $error("counter mode tick does not follow the selected edge");

  edge_polarity_a: assert property (
    (cfg_r.clk_src && cfg_r.edge_fall && ext_rise) |-> !ext_edge)
    else $error("rising edge counted while falling edge selected");

  timer_divided_a: assert property (
    (!cfg_r.psa_wdt && $stable(cfg_r) && inc_r) |=> !inc_r)
    else $error("prescaled timer advanced on two cycles in a row");

  wdt_owner_only_a: assert property (!cfg_r.psa_wdt |=> !wdt_tick_o)
    else $error("watchdog tick while prescaler serves the timer");

  presc_wrclr_a: assert property (
    (!cfg_r.psa_wdt && wr_count) |=> (presc_count == 8'h00))
    else $error("count write did not clear the prescaler");

  presc_wdtclr_a: assert property (
    (cfg_r.psa_wdt && watchdog_clear_i) |=> (presc_count == 8'h00))
    else $error("watchdog clear did not clear the prescaler");

  wrap_sets_flag_a: assert property (
    (ovf_evt && !overflow_int_enable_r) |=> (overflow_flag_r && timer_count_r == 8'h00))
    else $error("wrap did not set the overflow flag");

  flag_sticky_a: assert property (
    (overflow_flag_r && !flag_clear) |=> overflow_flag_r)
    else $error("overflow flag dropped without software clear");

  irq_cause_a: assert property (
    irq_o |-> $past(overflow_flag_r && overflow_int_enable_r && global_enable_r))
    else $error("interrupt raised without flag and both enables");

  irq_global_a: assert property (
    (overflow_flag_r && overflow_int_enable_r && !global_enable_r) |=> !irq_o)
    else $error("interrupt passed while global enable clear");

  sleep_frozen_a: assert property (
    (sleep_i && !wr_count) |=> (timer_count_r == $past(timer_count_r) && !$rose(overflow_flag_r)))
    else $error("count moved during sleep");

  // Bus answer: one wait state, a one-cycle ack, upper data bits zero
  ack_answer_a: assert property (bus_req |=> wb_ack_o)
    else $error("request not answered in the next cycle");

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  rd_high_zero_a: assert property (wb_ack_o |-> (wb_dat_o[31:8] == 24'h00_0000))
    else $error("read data above bit seven not zero");

  // Count register: it loads, steps by one or stands still
  count_load_a: assert property (wr_count |=> (timer_count_r == $past(req.dat)))
    else $error("count write did not load the written value");

  hold_count_a: assert property (wr_count |=> (hold_r == tmr8_pkg::WR_HOLD))
    else $error("count write did not start the hold window");

  count_step_a: assert property (inc_ok |=> (timer_count_r == $past(timer_count_r) + 8'h01))
    else $error("count did not advance by one");

  count_idle_a: assert property ((!inc_ok && !wr_count) |=> $stable(timer_count_r))
    else $error("count moved without an increment or a write");

  // Flag and interrupt
  flag_src_a: assert property ($rose(overflow_flag_r) |-> $past(ovf_evt))
    else $error("overflow flag set without a wrap");

  set_wins_a: assert property ((ovf_evt && flag_clear) |=> overflow_flag_r)
    else $error("clear beat a wrap in the same cycle");

  flag_clear_a: assert property ((flag_clear && !ovf_evt) |=> !overflow_flag_r)
    else $error("write of one did not clear the overflow flag");

  irq_level_a: assert property ((overflow_flag_r && overflow_int_enable_r && global_enable_r) |=> irq_o)
    else $error("interrupt missing with flag and both enables set");

  // Prescaler ownership and the count pin edges
  presc_owner_a: assert property (cfg_r.psa_wdt |-> (presc_in == wdt_tick_i))
    else $error("timer ticks reach a prescaler owned by the watchdog");

  wdt_pass_a: assert property ((cfg_r.psa_wdt && presc_out) |=> wdt_tick_o)
    else $error("prescaled watchdog tick not passed on");

  timer_no_bypass_a: assert property (!cfg_r.psa_wdt |-> (presc_shift != 4'h0))
    else $error("timer prescaler set to divide by one");

  presc_sleep_a: assert property ((!cfg_r.psa_wdt && sleep_i) |-> !presc_in)
    else $error("timer side prescaler ran in sleep");

  edge_excl_a: assert property (!(ext_rise && ext_fall))
    else $error("rising and falling edge reported together");

  ////////////////////////////////////////////////////////////////////////////
  // Coverage of the main scenarios
  wrap_seen_c:    cover property (ovf_evt);
  irq_seen_c:     cover property ($rose(irq_o));
  ext_count_c:    cover property (cfg_r.clk_src && inc_ok);
  clear_race_c:   cover property (ovf_evt && flag_clear);
  timer_div_c:    cover property (!cfg_r.psa_wdt && inc_ok);

endmodule // tmr8_top

// ===== testbench/test_timer8_with_shared_prescaler.sv
/*
  Self-checking bench: Wishbone tasks, watchdog pulses, count pin source, verdict.
  Assumes the timer top with its one 10 MHz clock and synchronous reset.
*/
`timescale 1ns/1ns
module test_timer8_with_shared_prescaler;
  localparam logic [3:0] A_CNT = tmr8_pkg::OFF_COUNT;
  localparam logic [3:0] A_CFG = tmr8_pkg::OFF_CONFIG;
  localparam logic [3:0] A_ST  = tmr8_pkg::OFF_STATUS;
  localparam logic [3:0] A_EN  = tmr8_pkg::OFF_INTEN;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        pin;
  logic        slp = 1'b0;
  logic        wd_clr = 1'b0;
  logic        wd_tick = 1'b0;
  logic        wd_out;
  logic        irq;
  logic        go = 1'b0;
  logic [7:0]  tgl = 8'h00;
  logic        busy;
  logic [7:0]  q;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc_cnt = 0;
  int          wd_seen = 0;
  int          stamp;
  int          base;
  int          tw;

  tmr8_top u_tmr8_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .external_count_input_i(pin), .sleep_i(slp), .watchdog_clear_i(wd_clr), .wdt_tick_i(wd_tick),
    .wdt_tick_o(wd_out), .irq_o(irq));
  tmr8_pulse_src u_tmr8_pulse_src (.clk_i(clk_i), .go_i(go), .toggles_i(tgl), .pin_o(pin), .busy_o(busy));

  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // Cycle stamps and watchdog pulses, old values seen at the same edge
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    wd_seen <= wd_seen + ((wd_out === 1'b1) ? 1 : 0);
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One classic cycle; held until ack is sampled high, bounded wait
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      print_verdict();
    end
    q = rdat[7:0];
    stamp = cyc_cnt;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, 4'h1, d);
  endtask
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 4'h0, 8'h00);
    chk(what, exp, q);
  endtask
  // One-cycle pulses on the watchdog clear (clr high) or on the watchdog base tick
  task automatic pulse(input logic clr, input int n);
    repeat (n) begin
      @(posedge clk_i);
      if (clr) begin
        wd_clr <= 1'b1;
      end else begin
        wd_tick <= 1'b1;
      end
      @(posedge clk_i);
      wd_clr  <= 1'b0;
      wd_tick <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
  endtask
  task automatic toggle_pin(input logic [7:0] n);
    int k;
    @(posedge clk_i);
    tgl <= n;
    go  <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (busy !== 1'b0 && k < 200);
    if (k >= 200) begin
      error_cnt++;
      print_verdict();
    end
    repeat (12) @(posedge clk_i);
  endtask
  // Counts over a window of exactly 8 prescaled periods; long ratios also probe the clear
  task automatic rate_chk(input logic [7:0] cfg, input int r);
    logic [7:0] c1;
    int         s1;
    wr(A_CFG, cfg);
    repeat (r / 2) @(posedge clk_i);
    wr(A_CNT, 8'h00);
    // Let the two held cycles after the write pass, so the first sample lies on the counting slope
    repeat ((r >= 32) ? r - 16 : 1) @(posedge clk_i);
    bus(1'b0, A_CNT, 4'h0, 8'h00);
    c1 = q;
    s1 = stamp;
    if (r >= 32) chk("count after write", 8'h00, c1);
    repeat (r * 8 - 3) @(posedge clk_i);
    bus(1'b0, A_CNT, 4'h0, 8'h00);
    chk("count rate", 8'((stamp - s1) / r), q - c1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("count reset", A_CNT, 8'h00);
    rd_chk("config reset", A_CFG, 8'h3f);
    rd_chk("status reset", A_ST, 8'h00);
    rd_chk("enable reset", A_EN, 8'h00);
    rd_chk("unmapped read", 4'h2, 8'h00);
    bus(1'b1, A_CFG, 4'h0, 8'h00);
    rd_chk("config sel off", A_CFG, 8'h3f);
    $display("test reset done");
    // Undivided timer and the two idle cycles after a count write
    rate_chk(8'h0f, 1);
    wr(A_CNT, 8'h40);
    tw = stamp;
    repeat (2) begin
      bus(1'b0, A_CNT, 4'h0, 8'h00);
      chk("count after write", 8'h40 + 8'((stamp - tw > 4) ? stamp - tw - 4 : 0), q);
    end
    $display("test timer done");
    // Overflow flag, enables and clearing
    wr(A_CNT, 8'hfe);
    repeat (10) @(posedge clk_i);
    rd_chk("flag on wrap", A_ST, 8'h01);
    chk("irq masked", 8'h00, {7'h0, irq});
    wr(A_EN, 8'h01);
    repeat (3) @(posedge clk_i);
    chk("irq no global", 8'h00, {7'h0, irq});
    wr(A_EN, 8'h03);
    repeat (3) @(posedge clk_i);
    chk("irq enabled", 8'h01, {7'h0, irq});
    repeat (50) @(posedge clk_i);
    rd_chk("flag sticky", A_ST, 8'h01);
    wr(A_ST, 8'h01);
    repeat (2) @(posedge clk_i);
    rd_chk("flag cleared", A_ST, 8'h00);
    chk("irq after clear", 8'h00, {7'h0, irq});
    $display("test overflow done");
    // Sleep freezes the count just below the wrap
    slp <= 1'b1;
    wr(A_CNT, 8'hfd);
    repeat (30) @(posedge clk_i);
    rd_chk("count in sleep", A_CNT, 8'hfd);
    rd_chk("flag in sleep", A_ST, 8'h00);
    slp <= 1'b0;
    repeat (20) @(posedge clk_i);
    rd_chk("flag after wake", A_ST, 8'h01);
    wr(A_ST, 8'h01);
    $display("test sleep done");
    // Watchdog to timer, then back, with the software sequences
    pulse(1'b1, 1);
    wr(A_CFG, 8'h00);
    base = wd_seen;
    pulse(1'b0, 8);
    chk("wdt blocked", 8'h00, 8'(wd_seen - base));
    pulse(1'b1, 1);
    wr(A_CNT, 8'h00);
    wr(A_CFG, 8'h08);
    pulse(1'b1, 1);
    wr(A_CFG, 8'h0a);
    base = wd_seen;
    pulse(1'b0, 3);
    pulse(1'b1, 1);
    pulse(1'b0, 3);
    chk("wdt after clear", 8'h00, 8'(wd_seen - base));
    pulse(1'b0, 1);
    chk("wdt one period", 8'h01, 8'(wd_seen - base));
    $display("test watchdog done");
    for (int n = 0; n < 8; n++) begin
      rate_chk(8'(n), 2 ** (n + 1));
    end
    $display("test prescale done");
    // Counter mode: five toggles give 3 of one edge and 2 of the other
    wr(A_CFG, 8'h38);
    wr(A_CNT, 8'h00);
    toggle_pin(8'h05);
    rd_chk("falling edges", A_CNT, 8'h02);
    wr(A_CFG, 8'h28);
    wr(A_CNT, 8'h00);
    toggle_pin(8'h05);
    rd_chk("rising edges", A_CNT, 8'h02);
    $display("test counter done");
    print_verdict();
  end
endmodule // test_timer8_with_shared_prescaler

// ===== testbench/tmr8_pulse_src.sv
/*
  Count pin source: toggles the external count pin a requested number of times.
  Assumes go_i is a one-cycle pulse on clk_i, given only while busy_o is low.
*/
`timescale 1ns/1ns
module tmr8_pulse_src #(
  parameter int HALF = 4
) (
  // Clock
  input  wire logic       clk_i,
  // Control
  input  wire logic       go_i,
  input  wire logic [7:0] toggles_i,
  // Pin and status
  output logic            pin_o,
  output logic            busy_o
);
  logic [7:0] left_r = 8'h00;
  int         tick_r = 0;
  logic       pin_r  = 1'b0;

  assign pin_o  = pin_r;
  assign busy_o = (left_r != 8'h00);

  // Each level lasts HALF cycles, so the pin synchroniser never misses one
  always @(posedge clk_i) begin
    if (go_i) begin
      left_r <= toggles_i;
      tick_r <= 0;
    end else if (left_r != 8'h00) begin
      tick_r <= (tick_r == HALF - 1) ? 0 : tick_r + 1;
      if (tick_r == HALF - 1) begin
        pin_r  <= ~pin_r;
        left_r <= left_r - 8'h01;
      end
    end
  end
endmodule // tmr8_pulse_src
